//--- sra_consts.svh
// Constants for the service request acknowledge and priority block.
// Assumes includers use the names below for addresses and bit fields.
`ifndef SRA_CONSTS_SVH
`define SRA_CONSTS_SVH
`define SRA_ADDR_CONFIG 8'h66
`define SRA_ADDR_MODEM_MATCH 8'h61
`define SRA_ADDR_TX_MATCH 8'h62
`define SRA_ADDR_RX_MATCH 8'h63
`define SRA_ADDR_MODEM_ACK 8'h75
`define SRA_ADDR_TX_ACK 8'h76
`define SRA_ADDR_RX_ACK 8'h77
`define SRA_BIT_PKG_TYPE 7
`define SRA_BIT_REG_ACK_EN 6
`define SRA_BIT_CHAIN_EN 5
`define SRA_BIT_GLOBAL 4
`define SRA_BIT_FAIR_OVR 3
`define SRA_BIT_RESERVED 2
`define SRA_BIT_AUTO 1
`define SRA_BIT_PRI_SEL 0
`define SRA_CONFIG_RESET 8'h00
`define SRA_MATCH_RESET 8'h00
`define SRA_CODE_NONE 3'h0
`define SRA_SYNC_RESET 21'h00_003F
`endif

//--- sra_pkg.sv
// Types shared by the acknowledge priority block and its resolver.
// Assumes nothing beyond a SystemVerilog compiler.
package sra_pkg;
  // Order gives the acknowledge type number: none 0, modem 1, transmit 2, receive 3
  typedef enum logic [1:0] {SRA_NONE, SRA_MODEM, SRA_TX, SRA_RX} sra_ack_t;
  typedef enum logic {SRA_IDLE, SRA_HELD} sra_state_t;
endpackage

//--- sra_pri_if.sv
// Carrier between the acknowledge controller and the priority resolver.
// Assumes both ends share one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface sra_pri_if;
  import sra_pkg::*;
  logic auto_pri;
  logic global_pri;
  logic pri_sel;
  sra_ack_t ack_type;
  logic [2:0] local_pend;
  logic [2:0] line_req;
  sra_ack_t win_type;
  logic win_pend;
  modport resolver (input auto_pri, global_pri, pri_sel, ack_type, local_pend, line_req, output win_type, win_pend);
  modport user (output auto_pri, global_pri, pri_sel, ack_type, local_pend, line_req, input win_type, win_pend);
endinterface // sra_pri_if
`default_nettype wire

//--- sra_resolve.sv
// Priority resolver: picks which request an acknowledge serves.
// Assumes vectors indexed modem 0, transmit 1, receive 2.
`timescale 1ns/100ps
`default_nettype none
module sra_resolve
  import sra_pkg::*;
(
  sra_pri_if.resolver pri
);
  logic [2:0] src;
  sra_ack_t pick;

  always_comb
  begin
    src = pri.global_pri ? pri.line_req : pri.local_pend;
    pick = SRA_NONE;
    if (pri.pri_sel)
    begin
      if (src[1]) pick = SRA_TX;
      else if (src[2]) pick = SRA_RX;
      else if (src[0]) pick = SRA_MODEM;
    end
    else
    begin
      if (src[2]) pick = SRA_RX;
      else if (src[1]) pick = SRA_TX;
      else if (src[0]) pick = SRA_MODEM;
    end
  end

  always_comb
  begin
    // Only modem-type acknowledges are reranked; others stay as asked
    if (pri.auto_pri && pri.ack_type == SRA_MODEM)
      pri.win_type = pick;
    else
      pri.win_type = pri.ack_type;
    case (pri.win_type)
      SRA_MODEM: pri.win_pend = pri.local_pend[0];
      SRA_TX: pri.win_pend = pri.local_pend[1];
      SRA_RX: pri.win_pend = pri.local_pend[2];
      default: pri.win_pend = 1'b0;
    endcase
  end
endmodule // sra_resolve
`default_nettype wire

//--- sra_ack_ctrl.sv
// Service request acknowledge and priority controller, host pin side.
// Assumes host pins are asynchronous and held stable through each strobe;
// pending and fair inputs come from channel logic on ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module sra_ack_ctrl
  import sra_pkg::*;
#(
  parameter logic PKG_TYPE = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [6:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic acknowledge_in_n,
  input wire logic [2:0] service_request_lines_i,
  input wire logic [2:0] local_pend,
  input wire logic [2:0] fair_in,
  input wire logic [7:0] vector_base,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  output logic acknowledge_out_n,
  output logic [2:0] service_request_lines_o,
  output logic [2:0] service_request_lines_oe,
  output logic [2:0] fair_bits,
  output logic [1:0] ack_level
);
  logic [20:0] pins, s1_q, s2_q;
  logic [6:0] addr_s;
  logic [7:0] wdata_s, addr8, addr_match, cfg_q, mmatch_q, tmatch_q, rmatch_q, rdata_q, reg_rd;
  logic rd_s, wr_s, acknowledge_in_n_s, rd_prev_q, wr_prev_q, acknowledge_in_n_prev_q;
  logic rd_fall, wr_fall, pin_ack, reg_ack, ack_event;
  logic oe_q, acknowledge_out_n_n_q;
  logic [2:0] req_oe_q, req_o_q, fair_q;
  logic [1:0] level_q;
  sra_ack_t ack_type;
  sra_state_t state_q;
  sra_pri_if pri ();

  assign pins = {host_addr, host_wdata, host_rd_n, host_wr_n, acknowledge_in_n, service_request_lines_i};

  // Two-stage synchronisers; only stage two is read by logic
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s1_q <= `SRA_SYNC_RESET;
      s2_q <= `SRA_SYNC_RESET;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  assign {addr_s, wdata_s, rd_s, wr_s, acknowledge_in_n_s} = s2_q[20:3];
  // Registers decode on seven lines; match values carry bit 7 as one
  assign addr8 = {1'b0, addr_s};
  assign addr_match = {1'b1, addr_s};

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
      acknowledge_in_n_prev_q <= 1'b1;
    end
    else
    begin
      rd_prev_q <= rd_s;
      wr_prev_q <= wr_s;
      acknowledge_in_n_prev_q <= acknowledge_in_n_s;
    end
  end

  assign rd_fall = rd_prev_q && !rd_s;
  assign wr_fall = wr_prev_q && !wr_s;

  // Pin acknowledge works whatever the chaining bit says
  assign pin_ack = acknowledge_in_n_prev_q && !acknowledge_in_n_s;
  assign reg_ack = rd_fall && cfg_q[`SRA_BIT_REG_ACK_EN]
    && (addr8 == `SRA_ADDR_MODEM_ACK || addr8 == `SRA_ADDR_TX_ACK || addr8 == `SRA_ADDR_RX_ACK);
  assign ack_event = (pin_ack || reg_ack) && state_q == SRA_IDLE;

  always_comb
  begin
    ack_type = SRA_NONE;
    if (pin_ack)
    begin
      if (addr_match == mmatch_q) ack_type = SRA_MODEM;
      else if (addr_match == tmatch_q) ack_type = SRA_TX;
      else if (addr_match == rmatch_q) ack_type = SRA_RX;
    end
    else if (addr8 == `SRA_ADDR_MODEM_ACK) ack_type = SRA_MODEM;
    else if (addr8 == `SRA_ADDR_TX_ACK) ack_type = SRA_TX;
    else if (addr8 == `SRA_ADDR_RX_ACK) ack_type = SRA_RX;
  end

  assign pri.auto_pri = cfg_q[`SRA_BIT_AUTO];
  assign pri.global_pri = cfg_q[`SRA_BIT_GLOBAL];
  assign pri.pri_sel = cfg_q[`SRA_BIT_PRI_SEL];
  assign pri.ack_type = ack_type;
  assign pri.local_pend = local_pend;
  assign pri.line_req = ~s2_q[2:0];

  sra_resolve u_resolve (
    .pri(pri)
  );

  // Register writes; reserved bit is kept at zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cfg_q <= `SRA_CONFIG_RESET;
      mmatch_q <= `SRA_MATCH_RESET;
      tmatch_q <= `SRA_MATCH_RESET;
      rmatch_q <= `SRA_MATCH_RESET;
    end
    else if (wr_fall)
    begin
      if (addr8 == `SRA_ADDR_CONFIG)
        cfg_q <= {1'b0, wdata_s[6:3], 1'b0, wdata_s[1:0]};
      else if (addr8 == `SRA_ADDR_MODEM_MATCH)
        mmatch_q <= wdata_s;
      else if (addr8 == `SRA_ADDR_TX_MATCH)
        tmatch_q <= wdata_s;
      else if (addr8 == `SRA_ADDR_RX_MATCH)
        rmatch_q <= wdata_s;
    end
  end

  always_comb
  begin
    if (addr8 == `SRA_ADDR_CONFIG)
      reg_rd = {PKG_TYPE, cfg_q[6:0]};
    else if (addr8 == `SRA_ADDR_MODEM_MATCH)
      reg_rd = mmatch_q;
    else if (addr8 == `SRA_ADDR_TX_MATCH)
      reg_rd = tmatch_q;
    else if (addr8 == `SRA_ADDR_RX_MATCH)
      reg_rd = rmatch_q;
    else
      reg_rd = 8'h00;
  end

  // Answer stands until both read and acknowledge strobes are released
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_q <= SRA_IDLE;
      rdata_q <= 8'h00;
      oe_q <= 1'b0;
      acknowledge_out_n_n_q <= 1'b1;
      level_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        SRA_IDLE:
        begin
          if (ack_event)
          begin
            state_q <= SRA_HELD;
            if (pri.win_pend)
            begin
              rdata_q <= {vector_base[7:3], 1'b0, pri.win_type};
              oe_q <= 1'b1;
              level_q <= pri.win_type;
            end
            else if (pin_ack || cfg_q[`SRA_BIT_CHAIN_EN])
              acknowledge_out_n_n_q <= 1'b0;
            else
            begin
              rdata_q <= {vector_base[7:3], `SRA_CODE_NONE};
              oe_q <= 1'b1;
              level_q <= 2'h0;
            end
          end
          else if (rd_fall)
          begin
            state_q <= SRA_HELD;
            rdata_q <= reg_rd;
            oe_q <= 1'b1;
          end
        end
        SRA_HELD:
        begin
          if (rd_s && acknowledge_in_n_s)
          begin
            state_q <= SRA_IDLE;
            oe_q <= 1'b0;
            acknowledge_out_n_n_q <= 1'b1;
            level_q <= 2'h0;
          end
        end
        default: state_q <= SRA_IDLE;
      endcase
    end
  end

  // Open-drain request lines; fair gating skipped under override
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      fair_q <= 3'h0;
      req_oe_q <= 3'h0;
      req_o_q <= 3'h0;
    end
    else
    begin
      fair_q <= cfg_q[`SRA_BIT_FAIR_OVR] ? 3'h7 : fair_in;
      req_oe_q <= local_pend & fair_q;
      req_o_q <= 3'h0;
    end
  end

  assign host_rdata = rdata_q;
  assign host_rdata_oe = oe_q;
  assign acknowledge_out_n = acknowledge_out_n_n_q;
  assign service_request_lines_o = req_o_q;
  assign service_request_lines_oe = req_oe_q;
  assign fair_bits = fair_q;
  assign ack_level = level_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_none_vector: assert property (reg_ack && ack_event && !pri.win_pend && !cfg_q[`SRA_BIT_CHAIN_EN]
    |=> host_rdata_oe && host_rdata[2:0] == 3'h0 && ack_level == 2'h0 && acknowledge_out_n)
    else $error("Untaken register acknowledge did not return code 000");
  a_regack_off: assert property (rd_fall && state_q == SRA_IDLE && !pin_ack && !cfg_q[`SRA_BIT_REG_ACK_EN]
    |=> acknowledge_out_n && ack_level == 2'h0)
    else $error("Register acknowledge accepted while disabled");
  a_pin_chain: assert property (pin_ack && ack_event && !pri.win_pend
    |=> !acknowledge_out_n && !host_rdata_oe)
    else $error("Pin acknowledge without pending request not passed");
  a_chain_pass: assert property (reg_ack && ack_event && !pri.win_pend && cfg_q[`SRA_BIT_CHAIN_EN]
    |=> !acknowledge_out_n [*2] or (!acknowledge_out_n ##1 acknowledge_out_n))
    else $error("Chained register acknowledge not passed onward");
  a_type_specific: assert property (ack_event && ack_type == SRA_TX && local_pend[1]
    |=> ack_level == 2'h2 && host_rdata[1:0] == 2'h2)
    else $error("Transmit acknowledge was reprioritised");
  a_local_rank: assert property (ack_event && ack_type == SRA_MODEM && cfg_q[`SRA_BIT_AUTO]
    && !cfg_q[`SRA_BIT_GLOBAL] && !cfg_q[`SRA_BIT_PRI_SEL] && local_pend[2] |=> ack_level == 2'h3)
    else $error("Receive did not rank first locally");
  a_global_rank: assert property (ack_event && ack_type == SRA_MODEM && cfg_q[`SRA_BIT_AUTO]
    && cfg_q[`SRA_BIT_GLOBAL] && cfg_q[`SRA_BIT_PRI_SEL] && !s2_q[1] && !local_pend[1]
    && !pin_ack && cfg_q[`SRA_BIT_CHAIN_EN] |=> !acknowledge_out_n)
    else $error("Global priority not taken from shared lines");
  a_fair_force: assert property (cfg_q[`SRA_BIT_FAIR_OVR] && $past(cfg_q[`SRA_BIT_FAIR_OVR])
    |-> fair_bits == 3'h7)
    else $error("Fair bits not forced under override");
  a_release: assert property (state_q == SRA_HELD && rd_s && acknowledge_in_n_s
    |=> !host_rdata_oe && acknowledge_out_n && ack_level == 2'h0 ##1 !host_rdata_oe)
    else $error("Answer not withdrawn on strobe release");

  c_reg_vector: cover property (reg_ack && ack_event && pri.win_pend);
  c_chain_pass: cover property (reg_ack && ack_event && !pri.win_pend && cfg_q[`SRA_BIT_CHAIN_EN]);
  c_auto_modem: cover property (ack_event && ack_type == SRA_MODEM && cfg_q[`SRA_BIT_AUTO] && pri.win_type == SRA_RX);
endmodule // sra_ack_ctrl
`default_nettype wire

//--- sra_peer_model.sv
// Peer controller pulls and the pulled-up shared request wires.
// Assumes every party pulls a wire low through its enable.
`timescale 1ns/100ps
`default_nettype none
module sra_peer_model
(
  input wire logic [2:0] dut_oe,
  input wire logic [2:0] peer_req,
  input wire logic wired_or,
  output logic [2:0] lines
);
  logic [2:0] pull;
  assign pull = dut_oe | peer_req;
  // Joined wires show any request on all three
  assign lines = wired_or ? {3{~|pull}} : ~pull;
endmodule // sra_peer_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the acknowledge priority controller.
// Assumes the peer model resolves the shared request wires.
`timescale 1ns/100ps
`default_nettype none
`include "sra_consts.svh"
module tb_top;
  localparam logic [7:0] V = 8'hA8;
  localparam logic [7:0] CFG = `SRA_ADDR_CONFIG;
  localparam logic [7:0] MA = `SRA_ADDR_MODEM_ACK;
  localparam logic [7:0] TA = `SRA_ADDR_TX_ACK;
  localparam logic [7:0] RA = `SRA_ADDR_RX_ACK;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [6:0] host_addr = 7'h00;
  logic [7:0] host_wdata = 8'h00;
  logic host_rd_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic acknowledge_in_n = 1'b1;
  logic [2:0] lines;
  logic [2:0] local_pend = 3'h0;
  logic [2:0] fair_in = 3'h0;
  logic [2:0] peer_req = 3'h0;
  logic wired_or = 1'b0;
  logic [7:0] host_rdata;
  logic host_rdata_oe;
  logic acknowledge_out_n;
  logic [2:0] req_oe;
  logic [2:0] req_o;
  logic [2:0] fair_bits;
  logic [1:0] ack_level;
  int error_cnt = 0;
  int total_checks = 0;

  always #50 ref_clk = ~ref_clk;

  sra_ack_ctrl dut
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .host_addr(host_addr),
    .host_wdata(host_wdata),
    .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n),
    .acknowledge_in_n(acknowledge_in_n),
    .service_request_lines_i(lines),
    .local_pend(local_pend),
    .fair_in(fair_in),
    .vector_base(V),
    .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe),
    .acknowledge_out_n(acknowledge_out_n),
    .service_request_lines_o(req_o),
    .service_request_lines_oe(req_oe),
    .fair_bits(fair_bits),
    .ack_level(ack_level)
  );

  sra_peer_model peer
  (
    .dut_oe(req_oe),
    .peer_req(peer_req),
    .wired_or(wired_or),
    .lines(lines)
  );

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a[6:0];
    host_wdata = d;
    host_wr_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    host_wr_n = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask

  // Read or pin acknowledge; data is judged only when driven
  task automatic ex(input logic pin, input logic [7:0] a, input logic [7:0] d, input logic [1:0] l,
    input logic o);
    int n;
    @(negedge ref_clk);
    host_addr = a[6:0];
    acknowledge_in_n = ~pin;
    host_rd_n = pin;
    n = 0;
    while (host_rdata_oe !== 1'b1 && acknowledge_out_n !== 1'b0 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (o)
      chk("rdata", host_rdata, d);
    chk("level", {6'h0, ack_level}, {6'h0, l});
    chk("ack_out", {7'h0, acknowledge_out_n}, {7'h0, o});
    host_rd_n = 1'b1;
    acknowledge_in_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    ex(0, CFG, 8'h80, 2'h0, 1'b1);
    wr(CFG, 8'h7B);
    ex(0, CFG, 8'hFB, 2'h0, 1'b1);
    $display("test config done");
    wr(CFG, 8'h00);
    local_pend = 3'h2;
    ex(0, TA, 8'h00, 2'h0, 1'b1);
    wr(CFG, 8'h40);
    ex(0, TA, V | 8'h02, 2'h2, 1'b1);
    local_pend = 3'h0;
    ex(0, MA, V, 2'h0, 1'b1);
    wr(CFG, 8'h60);
    ex(0, RA, V, 2'h0, 1'b0);
    local_pend = 3'h4;
    ex(0, RA, V | 8'h03, 2'h3, 1'b1);
    $display("test register ack done");
    wr(CFG, 8'h42);
    local_pend = 3'h7;
    ex(0, MA, V | 8'h03, 2'h3, 1'b1);
    wr(CFG, 8'h43);
    ex(0, MA, V | 8'h02, 2'h2, 1'b1);
    local_pend = 3'h6;
    ex(0, RA, V | 8'h03, 2'h3, 1'b1);
    local_pend = 3'h1;
    ex(0, MA, V | 8'h01, 2'h1, 1'b1);
    $display("test local priority done");
    fair_in = 3'h7;
    local_pend = 3'h2;
    peer_req = 3'h4;
    wr(CFG, 8'h52);
    ex(0, MA, V, 2'h0, 1'b1);
    wr(CFG, 8'h72);
    ex(0, MA, V, 2'h0, 1'b0);
    local_pend = 3'h4;
    peer_req = 3'h2;
    wr(CFG, 8'h73);
    ex(0, MA, V, 2'h0, 1'b0);
    local_pend = 3'h2;
    peer_req = 3'h0;
    wr(CFG, 8'h52);
    ex(0, MA, V | 8'h02, 2'h2, 1'b1);
    $display("test global priority done");
    wired_or = 1'b1;
    fair_in = 3'h0;
    local_pend = 3'h3;
    wr(CFG, 8'h4A);
    ex(0, MA, V | 8'h02, 2'h2, 1'b1);
    chk("fair", {5'h0, fair_bits}, 8'h07);
    chk("req_oe", {5'h0, req_oe}, 8'h03);
    chk("req_o", {5'h0, req_o}, 8'h00);
    fair_in = 3'h2;
    wr(CFG, 8'h42);
    chk("fair", {5'h0, fair_bits}, 8'h02);
    chk("req_oe", {5'h0, req_oe}, 8'h02);
    wired_or = 1'b0;
    $display("test fairness done");
    wr(`SRA_ADDR_MODEM_MATCH, 8'h91);
    wr(`SRA_ADDR_TX_MATCH, 8'h92);
    wr(`SRA_ADDR_RX_MATCH, 8'h93);
    wr(CFG, 8'h20);
    local_pend = 3'h0;
    ex(1, 8'h13, V, 2'h0, 1'b0);
    local_pend = 3'h2;
    ex(1, 8'h12, V | 8'h02, 2'h2, 1'b1);
    wr(CFG, 8'h00);
    local_pend = 3'h0;
    ex(1, 8'h11, V, 2'h0, 1'b0);
    wr(CFG, 8'h02);
    local_pend = 3'h5;
    ex(1, 8'h11, V | 8'h03, 2'h3, 1'b1);
    $display("test pin ack done");
    end_sim;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    #500000;
    error_cnt++;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
